// file: common/accg_pkg.sv
// shared constants and carriers for the adc core config and gain calibration bank
package accg_pkg;

	// register addresses, four-bit field of the command byte
	localparam logic [3:0] ADDR_RESULT_HIGH = 4'h0;
	localparam logic [3:0] ADDR_RESULT_MID = 4'h1;
	localparam logic [3:0] ADDR_RESULT_LOW = 4'h2;
	localparam logic [3:0] ADDR_GAIN_REF_DAC_CTRL = 4'h3;
	localparam logic [3:0] ADDR_FORMAT_RATE_CTRL = 4'h4;
	localparam logic [3:0] ADDR_DECIMATION_RATIO_LOW_LOW = 4'h5;
	localparam logic [3:0] ADDR_OFFSET_LOW = 4'h7;
	localparam logic [3:0] ADDR_OFFSET_MID = 4'h8;
	localparam logic [3:0] ADDR_OFFSET_HIGH = 4'h9;
	localparam logic [3:0] ADDR_GAIN_LOW = 4'hA;
	localparam logic [3:0] ADDR_GAIN_MID = 4'hB;
	localparam logic [3:0] ADDR_GAIN_HIGH = 4'hC;
	localparam logic [3:0] ADDR_DAC_A = 4'hE;
	localparam logic [3:0] ADDR_DAC_B = 4'hF;

	// command opcodes, upper nibble of the first byte
	localparam logic [3:0] OP_REG_READ = 4'h4;
	localparam logic [3:0] OP_REG_WRITE = 4'h5;
	localparam logic [3:0] OP_INTERNAL_GAIN_CAL = 4'h8;
	localparam logic [3:0] OP_EXTERNAL_GAIN_CAL = 4'h9;

	// reset value of every register in the map
	localparam logic [7:0] REG_RESET = 8'h00;

	// gain_reference_dac_control field positions
	localparam int AMP_GAIN_MSB = 7;
	localparam int AMP_GAIN_LSB = 5;
	localparam int OFFSET_ON_BIT = 4;
	localparam int GAIN_ON_BIT = 3;
	localparam int REF_SEL_BIT = 2;
	localparam int RANGE_MSB = 1;
	localparam int RANGE_LSB = 0;

	// format_detect_rate_control field positions
	localparam int FORMAT_BIT = 7;
	localparam int OVERLOAD_OFF_BIT = 6;
	localparam int OVERRANGE_OFF_BIT = 5;
	localparam int DIV_MSB = 4;
	localparam int DIV_LSB = 3;
	localparam int DECIMATION_RATIO_LOW_HI_MSB = 2;
	localparam int DECIMATION_RATIO_LOW_HI_LSB = 0;

	// arithmetic of the correction path
	localparam int GAIN_FRAC_BITS = 22;
	localparam logic [23:0] CODE_POS_FULL = 24'h7FFFFF;
	localparam logic [23:0] CODE_NEG_FULL = 24'h800000;
	localparam logic [9:0] MOD_DIV_BASE = 10'h040;
	localparam logic [1:0] RANGE_OFF = 2'h0;

	// command sequencer states
	typedef enum {ACCG_IDLE, ACCG_WR_DATA, ACCG_CAL_WAIT} accg_state_t;

	// steering handed to the modulator, filter and current dacs
	typedef struct packed {
		logic [2:0] amp_gain_sel;
		logic offset_correct_on;
		logic gain_correct_on;
		logic reference_pair_sel;
		logic [1:0] current_range_sel;
		logic offset_binary;
		logic overload_detect_off;
		logic overrange_detect_off;
		logic [1:0] mod_clk_div;
		logic [10:0] decimation_ratio_low_ratio;
		logic [7:0] current_dac_a_code;
		logic [7:0] current_dac_b_code;
	} accg_ctrl_t;

	// calibration request towards the modulator and filter
	typedef struct packed {
		logic start;
		logic external;
	} accg_cal_t;

endpackage : accg_pkg

// file: rtl/accg_regbank.sv
`timescale 1ns/1ps
// Contract
// - internal gain cal writes 24-bit gain coefficient
// - external gain cal writes coefficient from input
// - gain cal completion drives ready low
// - one-byte cal command, low nibble ignored
// - result bytes read-only, msb at zero
// - reset clears every register to zero
// - amp gain is two to code power
// - bit four enables offset correction
// - bit three enables gain correction
// - bit two picks low or high reference
// - range field: off, half, one, two mA
// - format bit: offset binary or two's complement
// - overload detection disabled when bit set
// - over-range detection disabled when bit set
// - modulator divider 64, 128, 256, 512
// - eleven-bit decimation from two registers
// - control write resets filter, ready goes high
// - offset coefficient bytes low to high ascending
// - gain coefficient bytes low to high ascending
// - each dac register holds 8-bit code
// - write command: opcode byte then data byte
// - read command returns addressed register
// - clip out-of-range result to full codes
// - over-range off halves output span
module accg_regbank
	import accg_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// command bytes from the serial front end
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_BYTE,
	input wire logic RESULT_HOLD,
	// read answer towards the serial front end
	output logic RD_VALID,
	output logic [7:0] RD_DATA,
	// raw conversion from the digital filter
	input wire logic RAW_VALID,
	input wire logic [23:0] RAW_CODE,
	input wire logic RAW_OVERLOAD,
	// calibration handshake with modulator and filter
	output accg_cal_t CAL_REQ,
	input wire logic CAL_DONE,
	input wire logic [23:0] CAL_COEFF,
	// steering of the analog side
	output accg_ctrl_t CTRL,
	output logic [7:0] AMP_GAIN_FACTOR,
	output logic [9:0] MOD_DIV_FACTOR,
	output logic DAC_ON,
	output logic MOD_RESET,
	// status pins
	output logic RESULT_READY_N,
	output logic RANGE_FAULT
);

	// register file
	logic [7:0] ctrl1_r; // gain, reference, dac range
	logic [7:0] ctrl2_r; // format, detection, divider, decimation_ratio_low high
	logic [7:0] decimation_ratio_low_r; // decimation low byte
	logic [23:0] offset_r; // offset coefficient
	logic [23:0] gain_r; // gain coefficient
	logic [7:0] dac_a_r; // first current dac code
	logic [7:0] dac_b_r; // second current dac code
	logic [23:0] result_r; // last corrected result

	// sequencer and pin state
	accg_state_t state_r;
	accg_state_t state_nxt;
	logic [3:0] wr_addr_r; // address held between the two write bytes
	logic rd_valid_r;
	logic [7:0] rd_data_r;
	logic cal_start_r;
	logic cal_ext_r;
	logic ready_n_r;
	logic fault_r;
	logic mod_reset_r;
	logic [7:0] amp_factor_r;
	logic [9:0] div_factor_r;
	logic dac_on_r;

	// command decode
	wire [3:0] cmd_op = CMD_BYTE[7:4];
	wire [3:0] cmd_addr = CMD_BYTE[3:0];
	wire idle_cmd = (state_r == ACCG_IDLE) && CMD_VALID;
	wire is_read = idle_cmd && (cmd_op == OP_REG_READ);
	wire is_write_op = idle_cmd && (cmd_op == OP_REG_WRITE);
	// low nibble plays no part in the calibration decode
	wire is_int_cal = idle_cmd && (cmd_op == OP_INTERNAL_GAIN_CAL);
	wire is_ext_cal = idle_cmd && (cmd_op == OP_EXTERNAL_GAIN_CAL);
	wire wr_en = (state_r == ACCG_WR_DATA) && CMD_VALID;
	wire cal_fin = (state_r == ACCG_CAL_WAIT) && CAL_DONE;

	// per-register write strobes; result addresses have none
	wire wr_ctrl1 = wr_en && (wr_addr_r == ADDR_GAIN_REF_DAC_CTRL);
	wire wr_ctrl2 = wr_en && (wr_addr_r == ADDR_FORMAT_RATE_CTRL);
	wire wr_decimation_ratio_low = wr_en && (wr_addr_r == ADDR_DECIMATION_RATIO_LOW_LOW);
	wire wr_off_l = wr_en && (wr_addr_r == ADDR_OFFSET_LOW);
	wire wr_off_m = wr_en && (wr_addr_r == ADDR_OFFSET_MID);
	wire wr_off_h = wr_en && (wr_addr_r == ADDR_OFFSET_HIGH);
	wire wr_gain_l = wr_en && (wr_addr_r == ADDR_GAIN_LOW);
	wire wr_gain_m = wr_en && (wr_addr_r == ADDR_GAIN_MID);
	wire wr_gain_h = wr_en && (wr_addr_r == ADDR_GAIN_HIGH);
	wire wr_dac_a = wr_en && (wr_addr_r == ADDR_DAC_A);
	wire wr_dac_b = wr_en && (wr_addr_r == ADDR_DAC_B);
	wire ctrl_wr = wr_ctrl1 || wr_ctrl2;

	// read view; unlisted addresses stay zero
	logic [7:0] reg_view [16];
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			reg_view[i] = REG_RESET;
		end
		reg_view[ADDR_RESULT_HIGH] = result_r[23:16];
		reg_view[ADDR_RESULT_MID] = result_r[15:8];
		reg_view[ADDR_RESULT_LOW] = result_r[7:0];
		reg_view[ADDR_GAIN_REF_DAC_CTRL] = ctrl1_r;
		reg_view[ADDR_FORMAT_RATE_CTRL] = ctrl2_r;
		reg_view[ADDR_DECIMATION_RATIO_LOW_LOW] = decimation_ratio_low_r;
		reg_view[ADDR_OFFSET_LOW] = offset_r[7:0];
		reg_view[ADDR_OFFSET_MID] = offset_r[15:8];
		reg_view[ADDR_OFFSET_HIGH] = offset_r[23:16];
		reg_view[ADDR_GAIN_LOW] = gain_r[7:0];
		reg_view[ADDR_GAIN_MID] = gain_r[15:8];
		reg_view[ADDR_GAIN_HIGH] = gain_r[23:16];
		reg_view[ADDR_DAC_A] = dac_a_r;
		reg_view[ADDR_DAC_B] = dac_b_r;
	end
	wire [7:0] rd_mux = reg_view[cmd_addr];

	// field extraction
	wire offset_on = ctrl1_r[OFFSET_ON_BIT];
	wire gain_on = ctrl1_r[GAIN_ON_BIT];
	wire offset_bin = ctrl2_r[FORMAT_BIT];
	wire overload_off = ctrl2_r[OVERLOAD_OFF_BIT];
	wire overrange_off = ctrl2_r[OVERRANGE_OFF_BIT];
	wire [2:0] amp_code = ctrl1_r[AMP_GAIN_MSB:AMP_GAIN_LSB];
	wire [1:0] div_code = ctrl2_r[DIV_MSB:DIV_LSB];

	// correction path: offset add, gain scale, then span handling
	wire signed [25:0] raw_ext = {{2{RAW_CODE[23]}}, RAW_CODE};
	wire signed [25:0] off_ext = offset_on ? {{2{offset_r[23]}}, offset_r} : 26'sh0;
	wire signed [25:0] off_sum = raw_ext + off_ext;
	// gain coefficient is unsigned with 22 fraction bits, so 400000h is unity
	wire signed [50:0] prod = off_sum * $signed({1'b0, gain_r});
	wire signed [50:0] prod_sh = prod >>> GAIN_FRAC_BITS;
	wire signed [50:0] scaled = gain_on ? prod_sh : {{25{off_sum[25]}}, off_sum};
	wire over_pos = !scaled[50] && (|scaled[49:23]);
	wire over_neg = scaled[50] && !(&scaled[49:23]);
	// halving fits 24 bits only with gain correction off; no clip is applied in that mode, so larger values wrap
	wire signed [50:0] halved = scaled >>> 1;
	wire [23:0] half_code = halved[23:0];
	wire [23:0] clip_code = over_pos ? CODE_POS_FULL : over_neg ? CODE_NEG_FULL : scaled[23:0];
	wire overload_hit = !overload_off && RAW_OVERLOAD;
	wire overrange_hit = !overrange_off && (over_pos || over_neg);
	wire [23:0] span_code = overrange_off ? half_code : clip_code;
	wire [23:0] load_code = overload_hit ? (RAW_CODE[23] ? CODE_NEG_FULL : CODE_POS_FULL) : span_code;
	// offset binary is two's complement with the sign inverted
	wire [23:0] fmt_code = {load_code[23] ^ offset_bin, load_code[22:0]};
	// a control write restarts the filter, so a result landing with it is dropped
	wire take_result = RAW_VALID && !RESULT_HOLD && (state_r != ACCG_CAL_WAIT) && !ctrl_wr;

	// next state of the command sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ACCG_IDLE: begin
				if (is_write_op) begin
					state_nxt = ACCG_WR_DATA;
				end else if (is_int_cal || is_ext_cal) begin
					state_nxt = ACCG_CAL_WAIT;
				end
			end
			ACCG_WR_DATA: begin
				if (CMD_VALID) begin
					state_nxt = ACCG_IDLE;
				end
			end
			ACCG_CAL_WAIT: begin
				if (CAL_DONE) begin
					state_nxt = ACCG_IDLE;
				end
			end
		endcase
	end

	// sequencer, write address and read answer
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= ACCG_IDLE;
			wr_addr_r <= 4'h0;
			rd_valid_r <= 1'b0;
			rd_data_r <= REG_RESET;
		end else begin
			state_r <= state_nxt;
			wr_addr_r <= is_write_op ? cmd_addr : wr_addr_r;
			rd_valid_r <= is_read;
			rd_data_r <= is_read ? rd_mux : rd_data_r;
		end
	end

	// control registers, all cleared by reset
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl1_r <= REG_RESET;
			ctrl2_r <= REG_RESET;
			decimation_ratio_low_r <= REG_RESET;
			dac_a_r <= REG_RESET;
			dac_b_r <= REG_RESET;
		end else begin
			ctrl1_r <= wr_ctrl1 ? CMD_BYTE : ctrl1_r;
			ctrl2_r <= wr_ctrl2 ? CMD_BYTE : ctrl2_r;
			decimation_ratio_low_r <= wr_decimation_ratio_low ? CMD_BYTE : decimation_ratio_low_r;
			dac_a_r <= wr_dac_a ? CMD_BYTE : dac_a_r;
			dac_b_r <= wr_dac_b ? CMD_BYTE : dac_b_r;
		end
	end

	// offset coefficient, byte-written by the host
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			offset_r <= {3{REG_RESET}};
		end else begin
			offset_r[7:0] <= wr_off_l ? CMD_BYTE : offset_r[7:0];
			offset_r[15:8] <= wr_off_m ? CMD_BYTE : offset_r[15:8];
			offset_r[23:16] <= wr_off_h ? CMD_BYTE : offset_r[23:16];
		end
	end

	// gain coefficient: calibration loads all three bytes at once
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			gain_r <= {3{REG_RESET}};
		end else if (cal_fin) begin
			gain_r <= CAL_COEFF;
		end else begin
			gain_r[7:0] <= wr_gain_l ? CMD_BYTE : gain_r[7:0];
			gain_r[15:8] <= wr_gain_m ? CMD_BYTE : gain_r[15:8];
			gain_r[23:16] <= wr_gain_h ? CMD_BYTE : gain_r[23:16];
		end
	end

	// result bytes, loaded only from the correction path
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			result_r <= {3{REG_RESET}};
			fault_r <= 1'b0;
		end else if (take_result) begin
			result_r <= fmt_code;
			fault_r <= overload_hit || overrange_hit;
		end
	end

	// calibration request pulse and mode
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			cal_start_r <= 1'b0;
			cal_ext_r <= 1'b0;
		end else begin
			cal_start_r <= is_int_cal || is_ext_cal;
			cal_ext_r <= is_ext_cal ? 1'b1 : is_int_cal ? 1'b0 : cal_ext_r;
		end
	end

	// ready pin: completion pulls low, control write or new cal releases it
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ready_n_r <= 1'b1;
		end else if (cal_fin || take_result) begin
			ready_n_r <= 1'b0;
		end else if (ctrl_wr || is_int_cal || is_ext_cal) begin
			ready_n_r <= 1'b1;
		end
	end

	// filter restart pulse and decoded analog steering
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			mod_reset_r <= 1'b0;
			amp_factor_r <= 8'h01;
			div_factor_r <= MOD_DIV_BASE;
			dac_on_r <= 1'b0;
		end else begin
			mod_reset_r <= ctrl_wr;
			amp_factor_r <= 8'h01 << amp_code;
			div_factor_r <= MOD_DIV_BASE << div_code;
			dac_on_r <= (ctrl1_r[RANGE_MSB:RANGE_LSB] != RANGE_OFF);
		end
	end

	// steering struct straight from the registers
	assign CTRL.amp_gain_sel = amp_code;
	assign CTRL.offset_correct_on = offset_on;
	assign CTRL.gain_correct_on = gain_on;
	assign CTRL.reference_pair_sel = ctrl1_r[REF_SEL_BIT];
	assign CTRL.current_range_sel = ctrl1_r[RANGE_MSB:RANGE_LSB];
	assign CTRL.offset_binary = offset_bin;
	assign CTRL.overload_detect_off = overload_off;
	assign CTRL.overrange_detect_off = overrange_off;
	assign CTRL.mod_clk_div = div_code;
	assign CTRL.decimation_ratio_low_ratio = {ctrl2_r[DECIMATION_RATIO_LOW_HI_MSB:DECIMATION_RATIO_LOW_HI_LSB], decimation_ratio_low_r};
	assign CTRL.current_dac_a_code = dac_a_r;
	assign CTRL.current_dac_b_code = dac_b_r;
	assign CAL_REQ.start = cal_start_r;
	assign CAL_REQ.external = cal_ext_r;
	assign AMP_GAIN_FACTOR = amp_factor_r;
	assign MOD_DIV_FACTOR = div_factor_r;
	assign DAC_ON = dac_on_r;
	assign MOD_RESET = mod_reset_r;
	assign RESULT_READY_N = ready_n_r;
	assign RANGE_FAULT = fault_r;
	assign RD_VALID = rd_valid_r;
	assign RD_DATA = rd_data_r;

endmodule : accg_regbank

// file: verification/accg_regbank_chk.sv
`timescale 1ns/1ps
// watches sequencer replies and steering outputs of the bank
module accg_regbank_chk
	import accg_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// command side
	input wire logic CMD_VALID,
	input wire logic [7:0] CMD_BYTE,
	input wire logic RD_VALID,
	// calibration side
	input wire accg_cal_t CAL_REQ,
	input wire logic CAL_DONE,
	// steering and status
	input wire accg_ctrl_t CTRL,
	input wire logic [7:0] AMP_GAIN_FACTOR,
	input wire logic [9:0] MOD_DIV_FACTOR,
	input wire logic DAC_ON,
	input wire logic MOD_RESET,
	input wire logic RESULT_READY_N
);
	logic wr_r; // data byte of a write is due
	logic cw_r; // waiting for calibration done
	logic [3:0] wa_r; // address of the pending write
	wire [3:0] op = CMD_BYTE[7:4];
	wire take = CMD_VALID && !wr_r && !cw_r;
	wire wdat = CMD_VALID && wr_r;
	wire cwr = wdat && (wa_r == ADDR_GAIN_REF_DAC_CTRL || wa_r == ADDR_FORMAT_RATE_CTRL);
	// shadow of the sequencer; cal wait ends only on done
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_r <= 1'b0;
			cw_r <= 1'b0;
			wa_r <= 4'h0;
		end else begin
			wr_r <= (take && op == OP_REG_WRITE) || (wr_r && !CMD_VALID);
			wa_r <= CMD_VALID ? CMD_BYTE[3:0] : wa_r;
			cw_r <= (take && op[3:1] == 3'h4) || (cw_r && !CAL_DONE);
		end
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	property p_rd; take && op == OP_REG_READ |=> RD_VALID; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_cal; take && op[3:1] == 3'h4 |=> CAL_REQ.start && CAL_REQ.external == $past(CMD_BYTE[4]); endproperty
	a_cal: assert property (p_cal) else $error("cal request wrong");
	property p_done; cw_r && CAL_DONE |=> !RESULT_READY_N && !CAL_REQ.start; endproperty
	a_done: assert property (p_done) else $error("ready not low after cal");
	property p_quiet; cw_r && CMD_VALID |=> !RD_VALID && !MOD_RESET; endproperty
	a_quiet: assert property (p_quiet) else $error("byte taken during cal");
	property p_ctlwr; cwr |=> MOD_RESET && RESULT_READY_N ##1 !MOD_RESET; endproperty
	a_ctlwr: assert property (p_ctlwr) else $error("control write reset wrong");
	property p_decimation_ratio_low; wdat && wa_r == ADDR_DECIMATION_RATIO_LOW_LOW |=> CTRL.decimation_ratio_low_ratio[7:0] == $past(CMD_BYTE); endproperty
	a_decimation_ratio_low: assert property (p_decimation_ratio_low) else $error("decimation low wrong");
	property p_amp; AMP_GAIN_FACTOR == 8'h01 << $past(CTRL.amp_gain_sel); endproperty
	a_amp: assert property (p_amp) else $error("amp factor wrong");
	property p_div; MOD_DIV_FACTOR == MOD_DIV_BASE << $past(CTRL.mod_clk_div); endproperty
	a_div: assert property (p_div) else $error("divider wrong");
	property p_dac; DAC_ON == ($past(CTRL.current_range_sel) != RANGE_OFF); endproperty
	a_dac: assert property (p_dac) else $error("dac enable wrong");
	// main scenarios reached
	c_rd: cover property (take && op == OP_REG_READ);
	c_done: cover property (cw_r && CAL_DONE);
	c_ctlwr: cover property (cwr);
endmodule : accg_regbank_chk
bind accg_regbank accg_regbank_chk accg_regbank_chk_i (.CORE_CLK, .RSTN, .CMD_VALID, .CMD_BYTE,
	.RD_VALID, .CAL_REQ, .CAL_DONE, .CTRL, .AMP_GAIN_FACTOR, .MOD_DIV_FACTOR, .DAC_ON,
	.MOD_RESET, .RESULT_READY_N);

// file: verification/accg_cal_model.sv
`timescale 1ns/1ps
// filter side answering gain calibration requests after a set delay
module accg_cal_model
	import accg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request and answer
	input wire accg_cal_t cal_req,
	input wire logic [7:0] delay,
	input wire logic [23:0] coeff,
	output logic cal_done,
	output logic [23:0] cal_coeff
);
	logic [7:0] cnt_r; // cycles left until done
	logic [23:0] junk_r; // changes every cycle so stale data never matches
	// coefficient valid only with the done pulse
	assign cal_coeff = cal_done ? coeff : junk_r;
	// delay counter, restarted by every start pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			cal_done <= 1'b0;
			junk_r <= 24'h5A5A5A;
		end else begin
			junk_r <= ~junk_r;
			cal_done <= cnt_r == 8'h01;
			cnt_r <= cal_req.start ? delay : cnt_r - 8'(cnt_r != 8'h00);
		end
	end
endmodule : accg_cal_model

// file: verification/adc_core_config_and_gain_calibration_bench.sv
`timescale 1ns/1ps
// drives command bytes and raw results, models the register map
module adc_core_config_and_gain_calibration_bench
	import accg_pkg::*;
;
	logic CORE_CLK, RSTN, CMD_VALID, RESULT_HOLD, RAW_VALID, RAW_OVERLOAD, RD_VALID, CAL_DONE;
	logic DAC_ON, MOD_RESET, RESULT_READY_N, RANGE_FAULT;
	logic [7:0] CMD_BYTE, RD_DATA, AMP_GAIN_FACTOR, dly;
	logic [23:0] RAW_CODE, CAL_COEFF, cf;
	logic [9:0] MOD_DIV_FACTOR;
	accg_cal_t CAL_REQ;
	accg_ctrl_t CTRL;
	logic [7:0] e [16]; // expected register map
	int num_errors, checked;
	accg_regbank accg_regbank_i (.CORE_CLK, .RSTN, .CMD_VALID, .CMD_BYTE, .RESULT_HOLD,
		.RD_VALID, .RD_DATA, .RAW_VALID, .RAW_CODE, .RAW_OVERLOAD, .CAL_REQ, .CAL_DONE,
		.CAL_COEFF, .CTRL, .AMP_GAIN_FACTOR, .MOD_DIV_FACTOR, .DAC_ON, .MOD_RESET,
		.RESULT_READY_N, .RANGE_FAULT);
	accg_cal_model accg_cal_model_i (.clk(CORE_CLK), .rst_n(RSTN), .cal_req(CAL_REQ),
		.delay(dly), .coeff(cf), .cal_done(CAL_DONE), .cal_coeff(CAL_COEFF));
	task chk(string n, logic [39:0] seen, logic [39:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task complete_run;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	// one byte, held for one edge, then a gap
	task send(logic [7:0] b);
		@(posedge CORE_CLK);
		CMD_VALID <= 1'b1;
		CMD_BYTE <= b;
		@(posedge CORE_CLK);
		CMD_VALID <= 1'b0;
		CMD_BYTE <= ~b;
	endtask : send
	task wr(logic [3:0] a, logic [7:0] d);
		send({OP_REG_WRITE, a});
		send(d);
		if (a inside {[3:5], [7:12], 14, 15}) e[a] = d;
	endtask : wr
	task rd(logic [3:0] a);
		send({OP_REG_READ, a});
		#1;
		chk("rd_valid", RD_VALID, 1);
		chk("rd_data", RD_DATA, e[a]);
	endtask : rd
	// corrected result, with the range fault flag above it, as the host should see them
	function logic [24:0] res_f(logic [23:0] r, logic o);
		logic signed [49:0] s;
		logic f;
		s = $signed(r);
		if (e[3][4]) s = s + $signed({e[9], e[8], e[7]});
		if (e[3][3]) s = (s * $signed({1'b0, e[12], e[11], e[10]})) >>> 22;
		f = !e[4][5] && (s > 50'sh7FFFFF || s < -50'sh800000);
		if (e[4][5]) s = s >>> 1;
		else if (s > 50'sh7FFFFF) s = 50'sh7FFFFF;
		else if (s < -50'sh800000) s = -50'sh800000;
		f = f || (!e[4][6] && o);
		if (!e[4][6] && o) s = r[23] ? -50'sh800000 : 50'sh7FFFFF;
		return {f, s[23:0] ^ {e[4][7], 23'h0}};
	endfunction : res_f
	task raw(logic [23:0] r, logic o);
		logic [24:0] rv;
		@(posedge CORE_CLK);
		RAW_VALID <= 1'b1;
		RAW_CODE <= r;
		RAW_OVERLOAD <= o;
		@(posedge CORE_CLK);
		RAW_VALID <= 1'b0;
		rv = res_f(r, o);
		{e[0], e[1], e[2]} = rv[23:0];
		for (int a = 0; a < 3; a++) rd(4'(a));
		// fault stands until the next taken result, ready until a control write or cal command
		chk("range_fault", RANGE_FAULT, rv[24]);
		chk("ready_low", RESULT_READY_N, 0);
	endtask : raw
	// gain calibration with a read that must be refused meanwhile
	task cal(logic [7:0] b);
		int i;
		cf = 24'($urandom);
		dly = 8'h05 + 8'($urandom_range(19, 0));
		send(b);
		#1;
		chk("cal_ready_high", RESULT_READY_N, 1);
		send({OP_REG_READ, ADDR_GAIN_LOW});
		#1;
		chk("rd_refused", RD_VALID, 0);
		for (i = 0; i < 300 && RESULT_READY_N !== 1'b0; i++) begin
			@(posedge CORE_CLK);
			#1;
		end
		chk("cal_done", i < 300, 1);
		if (i == 300) complete_run;
		{e[12], e[11], e[10]} = cf;
		for (int a = 10; a < 13; a++) rd(4'(a));
	endtask : cal
	initial begin
		CORE_CLK = 1'b0;
		forever #2 CORE_CLK = ~CORE_CLK;
	end
	initial begin
		{RSTN, CMD_VALID, CMD_BYTE, RESULT_HOLD, RAW_VALID, RAW_CODE, RAW_OVERLOAD} = '0;
		dly = 8'h05;
		cf = 24'h000000;
		foreach (e[k]) e[k] = 8'h00;
		void'($urandom(13275));
		repeat (2) @(posedge CORE_CLK);
		RSTN <= 1'b1;
		for (int a = 0; a < 16; a++) rd(4'(a));
		chk("amp_rst", AMP_GAIN_FACTOR, 8'h01);
		// an offset calibration opcode is not decoded, so the read after it must answer
		send({3'h3, 5'($urandom)});
		rd(ADDR_DAC_B);
		$display("test reset values done");
		for (int a = 0; a < 16; a++) begin
			wr(4'(a), 8'($urandom));
			rd(4'(a));
		end
		$display("test write and read back done");
		// reset again with the map full of data
		@(posedge CORE_CLK);
		RSTN <= 1'b0;
		repeat (2) @(posedge CORE_CLK);
		RSTN <= 1'b1;
		foreach (e[k]) e[k] = 8'h00;
		for (int a = 0; a < 16; a++) rd(4'(a));
		$display("test mid-run reset done");
		// every gain and divider code, with a random range code
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_GAIN_REF_DAC_CTRL, {3'(k), 5'($urandom)});
			wr(ADDR_FORMAT_RATE_CTRL, {3'($urandom), 2'(k), 3'($urandom)});
			@(posedge CORE_CLK);
			#1;
			chk("ctrl", CTRL, {e[3], e[4], e[5], e[14], e[15]});
			chk("amp", AMP_GAIN_FACTOR, 8'h01 << k);
			chk("div", MOD_DIV_FACTOR, 10'h040 << k[1:0]);
			chk("dac", DAC_ON, e[3][1:0] != 2'h0);
		end
		$display("test control codes done");
		for (int k = 0; k < 12; k++) begin
			for (int a = 7; a < 13; a++) wr(4'(a), 8'($urandom));
			wr(ADDR_FORMAT_RATE_CTRL, 8'($urandom));
			wr(ADDR_GAIN_REF_DAC_CTRL, 8'($urandom));
			#1;
			chk("mod_reset", MOD_RESET, 1);
			chk("ready_high", RESULT_READY_N, 1);
			raw(k == 0 ? 24'h7FFFFF : k == 1 ? 24'h800000 : 24'($urandom), 1'($urandom));
		end
		// a held result register must not take a new conversion
		@(posedge CORE_CLK);
		RESULT_HOLD <= 1'b1;
		RAW_VALID <= 1'b1;
		RAW_CODE <= 24'($urandom);
		@(posedge CORE_CLK);
		RAW_VALID <= 1'b0;
		RESULT_HOLD <= 1'b0;
		for (int a = 0; a < 3; a++) rd(4'(a));
		$display("test result path done");
		cal({OP_INTERNAL_GAIN_CAL, 4'($urandom)});
		cal({OP_EXTERNAL_GAIN_CAL, 4'hF});
		cal({OP_EXTERNAL_GAIN_CAL, 4'h0});
		$display("test gain calibration done");
		complete_run;
	end
endmodule : adc_core_config_and_gain_calibration_bench
